// file: testbench.sv
// Self-checking bench for the option control register and its datapath
`timescale 1ns/100ps
module testbench;
    logic       clk_sys = 1'b0;
    logic       rst = 1'b1;
    logic [8:0] bus_addr = 9'h000;
    logic       bus_wr = 1'b0;
    logic [7:0] bus_wdata = 8'h00;
    logic       icc = 1'b0, irq = 1'b0, wtk = 1'b0, fclr = 1'b0, go = 1'b0;
    logic [7:0] latch = 8'h00, edges = 8'h00, rdata, pu, tcnt, v, t0;
    logic       hit, flag, ovf, wto, pin, busy;
    tpo_pkg::tpo_option_t opt;
    int         err_total = 0, num_checks = 0, seed = 32'hC549, wd_cnt = 0, n;
    int         ov_cnt = 0;
    always #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (wto) wd_cnt <= wd_cnt + 1;
    always @(posedge clk_sys) if (ovf) ov_cnt <= ov_cnt + 1;
    tpo_option_ctrl tpo_option_ctrl_inst (.clk_sys, .rst, .bus_addr, .bus_wr, .bus_wdata,
        .bus_rdata(rdata), .bus_hit(hit), .instruction_cycle_clock(icc),
        .timer_ext_clock_pin(pin), .ext_irq_pin(irq), .watchdog_clock_tick(wtk),
        .ext_irq_flag_clear(fclr), .second_io_port_latch(latch),
        .second_io_port_pullup_en(pu), .ext_irq_flag(flag), .timer_zero_count(tcnt),
        .timer_zero_overflow(ovf), .watchdog_timeout_tick(wto), .option_out(opt));
    tpo_ext_src tpo_ext_src_inst (.clk_sys, .go, .edges, .pin, .busy);
    function automatic int div(input bit wd, input logic [2:0] c);
        return 1 << (c + (wd ? 0 : 1));
    endfunction : div
    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wt(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask : wt
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus_addr  <= a;
        bus_wr    <= 1'b1;
        bus_wdata <= d;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [8:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        bus_addr <= a;
        wt(1);
        d = rdata;
    endtask : rd
    // Pulses on the watchdog tick or the instruction clock
    task automatic tick(input bit w, input int k);
        repeat (k) begin
            @(posedge clk_sys);
            wtk <= w;
            icc <= !w;
            @(posedge clk_sys);
            wtk <= 1'b0;
            icc <= 1'b0;
        end
        wt(4);
    endtask : tick
    task automatic src(input logic [7:0] k);
        @(posedge clk_sys);
        edges <= k;
        go    <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        for (int i = 0; i < 400 && (busy || i < 2); i++) @(posedge clk_sys);
        if (busy) begin
            err_total++;
            $display("BAD %0t pulse source timed out", $time);
            print_verdict();
        end
        wt(6);
    endtask : src
    initial begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        rd(9'h081, v);
        chk(v, 8'hFF);
        for (int i = 0; i < 4; i++) begin
            v = 8'($random(seed));
            wr(i[0] ? 9'h181 : 9'h081, v);
            wr(9'h101, ~v);
            rd(i[0] ? 9'h081 : 9'h181, t0);
            chk(t0, v);
            chk({7'h00, hit}, 8'h01);
            chk(8'(opt), v);
            rd(9'h101, t0);
            chk(t0, 8'h00);
            chk({7'h00, hit}, 8'h00);
        end
        for (int i = 0; i < 4; i++) begin
            latch <= 8'($random(seed));
            wr(9'h081, {i[0], 7'h7F});
            wt(1);
            chk(pu, i[0] ? 8'h00 : ~latch);
        end
        for (int c = 0; c < 8; c++) begin
            wr(9'h081, {5'b11000, c[2:0]});
            t0 = tcnt;
            tick(0, 3 * div(0, c));
            chk(tcnt - t0, 8'h03);
        end
        t0 = tcnt;
        src(8'h02);
        chk(tcnt - t0, 8'h00);
        // Rewrite mid-count must drop the partial prescale
        wr(9'h081, 8'hC1);
        tick(0, 3);
        wr(9'h081, 8'hC1);
        t0 = tcnt;
        tick(0, 3);
        chk(tcnt - t0, 8'h00);
        tick(0, 1);
        chk(tcnt - t0, 8'h01);
        wr(9'h081, 8'hC8);
        t0 = tcnt;
        tick(0, 5);
        chk(tcnt - t0, 8'h05);
        for (int c = 0; c < 8; c++) begin
            wr(9'h081, {5'b11001, c[2:0]});
            n = wd_cnt;
            tick(1, 2 * div(1, c));
            chk(8'(wd_cnt - n), 8'h02);
        end
        wr(9'h081, 8'hC7);
        n = wd_cnt;
        tick(1, 3);
        chk(8'(wd_cnt - n), 8'h03);
        // Undivided count runs exactly up to the wrap
        wr(9'h081, 8'hC8);
        n = ov_cnt;
        tick(0, 256 - tcnt);
        chk(tcnt, 8'h00);
        chk(8'(ov_cnt - n), 8'h01);
        for (int e = 0; e < 2; e++) begin
            wr(9'h081, {3'b111, e[0], 4'b1000});
            t0 = tcnt;
            src(8'h01);
            chk(tcnt - t0, e[0] ? 8'h00 : 8'h01);
            src(8'h01);
            chk(tcnt - t0, 8'h01);
        end
        for (int e = 0; e < 2; e++) begin
            wr(9'h081, {1'b1, e[0], 6'h3F});
            irq <= e[0];
            wt(6);
            fclr <= 1'b1;
            wt(1);
            fclr <= 1'b0;
            irq  <= !e[0];
            wt(6);
            chk(flag, 1'b0);
            irq <= e[0];
            // Clear lands on the edge that sets the flag: set must win
            wt(2);
            fclr <= 1'b1;
            wt(1);
            fclr <= 1'b0;
            wt(3);
            chk(flag, 1'b1);
        end
        print_verdict();
    end
endmodule : testbench

// file: tpo_consts.svh
// Register offsets, field positions and reset values for the option control block
`ifndef TPO_CONSTS_SVH
`define TPO_CONSTS_SVH
`define TPO_ADDR_BANK1      9'h081
`define TPO_ADDR_BANK3      9'h181
`define TPO_OPT_RESET       8'hFF
`define TPO_BIT_PULLUP_N    7
`define TPO_BIT_IRQ_EDGE    6
`define TPO_BIT_CLK_SRC     5
`define TPO_BIT_T0_EDGE     4
`define TPO_BIT_ASSIGN      3
`define TPO_RATE_MSB        2
`define TPO_RATE_LSB        0
`define TPO_PRESC_W         8
`define TPO_PRESC_ZERO      8'h00
`endif

// file: tpo_ext_src.sv
// Model of the pulse source on the external timer clock pin
`timescale 1ns/100ps
module tpo_ext_src (
    input  wire logic       clk_sys,
    input  wire logic       go,
    input  wire logic [7:0] edges,
    output logic            pin,
    output logic            busy
);
    logic [7:0] left_q = 8'h00;
    logic [1:0] gap_q  = 2'h0;
    assign busy = (left_q != 8'h00);
    initial pin = 1'b0;
    // Four cycles per level so the pin synchroniser never misses one
    always @(posedge clk_sys) begin
        gap_q <= gap_q + 2'h1;
        if (go) begin
            left_q <= edges;
            gap_q  <= 2'h0;
        end else if (busy && gap_q == 2'h3) begin
            pin    <= ~pin;
            left_q <= left_q - 8'h01;
        end
    end
endmodule : tpo_ext_src

// file: tpo_option_ctrl.sv
// Timer0 / watchdog prescaler option control register with its datapath
`timescale 1ns/100ps
`include "tpo_consts.svh"
module tpo_option_ctrl (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic [8:0] bus_addr,
    input  wire logic       bus_wr,
    input  wire logic [7:0] bus_wdata,
    output logic      [7:0] bus_rdata,
    output logic            bus_hit,
    input  wire logic       instruction_cycle_clock,
    input  wire logic       timer_ext_clock_pin,
    input  wire logic       ext_irq_pin,
    input  wire logic       watchdog_clock_tick,
    input  wire logic       ext_irq_flag_clear,
    input  wire logic [7:0] second_io_port_latch,
    output logic      [7:0] second_io_port_pullup_en,
    output logic            ext_irq_flag,
    output logic      [7:0] timer_zero_count,
    output logic            timer_zero_overflow,
    output logic            watchdog_timeout_tick,
    output tpo_pkg::tpo_option_t option_out
);
    tpo_pkg::tpo_state_t s_q;
    tpo_pkg::tpo_state_t s_d;
    logic presc_in;
    logic presc_out;
    logic presc_clr;
    logic t0_src_pulse;
    logic t0_ext_edge;
    logic irq_edge;
    logic opt_wr;

    function automatic logic addr_match(input logic [8:0] a);
        addr_match = (a == `TPO_ADDR_BANK1) || (a == `TPO_ADDR_BANK3);
    endfunction : addr_match

    assign opt_wr = bus_wr && addr_match(bus_addr);
    // Assignment or rate rewrite restarts the divider from zero
    assign presc_clr = opt_wr;

    // Bit 4 high counts falling pin edges, low counts rising
    assign t0_ext_edge = s_q.opt.timer_zero_edge_select ?
                         (s_q.t0_prev && !s_q.t0_s2) :
                         (!s_q.t0_prev && s_q.t0_s2);
    assign t0_src_pulse = s_q.opt.timer_zero_clock_source ?
                          t0_ext_edge : instruction_cycle_clock;
    assign irq_edge = s_q.opt.ext_irq_edge_select ?
                      (!s_q.irq_prev && s_q.irq_s2) :
                      (s_q.irq_prev && !s_q.irq_s2);

    // Divider input follows the assignment bit, so a change acts from the next input pulse
    assign presc_in = s_q.opt.prescaler_assignment ?
                      watchdog_clock_tick : t0_src_pulse;

    // Watchdog side taps one stage lower: 1:1 at code 000 by bypass there
    tpo_prescaler #(
        .W (`TPO_PRESC_W)
    ) u_presc (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .clr       (presc_clr),
        .in_pulse  (presc_in),
        .tap       (s_q.opt.prescaler_assignment ?
                    s_q.opt.prescale_rate_code - 3'h1 : s_q.opt.prescale_rate_code),
        .bypass    (s_q.opt.prescaler_assignment &&
                    (s_q.opt.prescale_rate_code == 3'h0)),
        .out_pulse (presc_out)
    );

    always_comb begin
        s_d             = s_q;
        s_d.t0_s1       = timer_ext_clock_pin;
        s_d.t0_s2       = s_q.t0_s1;
        s_d.t0_prev     = s_q.t0_s2;
        s_d.irq_s1      = ext_irq_pin;
        s_d.irq_s2      = s_q.irq_s1;
        s_d.irq_prev    = s_q.irq_s2;
        s_d.t0_overflow = 1'b0;
        if (opt_wr) begin
            s_d.opt = tpo_pkg::tpo_option_t'(bus_wdata);
        end
        // Undivided path when the divider belongs to the watchdog
        if (s_q.opt.prescaler_assignment ? t0_src_pulse : presc_out) begin
            s_d.timer_zero_count = s_q.timer_zero_count + 8'h01;
            s_d.t0_overflow      = (s_q.timer_zero_count == 8'hFF);
        end
        // Set wins over a simultaneous clear
        if (irq_edge) begin
            s_d.irq_flag = 1'b1;
        end else if (ext_irq_flag_clear) begin
            s_d.irq_flag = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_q     <= '0;
            s_q.opt <= `TPO_OPT_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus_hit   = addr_match(bus_addr);
    assign bus_rdata = bus_hit ? 8'(s_q.opt) : 8'h00;
    assign second_io_port_pullup_en = s_q.opt.port_pullup_disable_n ?
                                      8'h00 : ~second_io_port_latch;
    assign ext_irq_flag          = s_q.irq_flag;
    assign timer_zero_count      = s_q.timer_zero_count;
    assign timer_zero_overflow   = s_q.t0_overflow;
    assign watchdog_timeout_tick = s_q.opt.prescaler_assignment ? presc_out
                                   : watchdog_clock_tick;
    assign option_out            = s_q.opt;

    // Register access
    a_opt_write_both: assert property (@(posedge clk_sys) disable iff (rst)
        opt_wr |=> 8'(s_q.opt) == $past(bus_wdata))
        else $error("option write lost");
    a_opt_refused: assert property (@(posedge clk_sys) disable iff (rst)
        (bus_wr && !bus_hit) |=> $stable(s_q.opt))
        else $error("option changed by foreign write");
    a_opt_reset: assert property (@(posedge clk_sys)
        rst |=> 8'(s_q.opt) == `TPO_OPT_RESET)
        else $error("option reset value wrong");

    // Port pull-ups
    a_pullup_off: assert property (@(posedge clk_sys) disable iff (rst)
        s_q.opt.port_pullup_disable_n |-> second_io_port_pullup_en == 8'h00)
        else $error("pull-ups active while disabled");
    a_pullup_on: assert property (@(posedge clk_sys) disable iff (rst)
        !s_q.opt.port_pullup_disable_n |->
        second_io_port_pullup_en == ~second_io_port_latch)
        else $error("pull-ups not following latches");

    // External interrupt flag
    a_irq_rise: assert property (@(posedge clk_sys) disable iff (rst)
        (s_q.opt.ext_irq_edge_select && $rose(s_q.irq_s2)) |=> ext_irq_flag)
        else $error("rising edge missed");
    a_irq_fall: assert property (@(posedge clk_sys) disable iff (rst)
        (!s_q.opt.ext_irq_edge_select && $fell(s_q.irq_s2)) |=> ext_irq_flag)
        else $error("falling edge missed");
    a_irq_sets: assert property (@(posedge clk_sys) disable iff (rst)
        irq_edge |=> ext_irq_flag)
        else $error("irq flag not set");
    a_irq_no_spurious: assert property (@(posedge clk_sys) disable iff (rst)
        (!ext_irq_flag && !irq_edge) |=> !ext_irq_flag)
        else $error("irq flag set without edge");
    a_irq_clear: assert property (@(posedge clk_sys) disable iff (rst)
        (ext_irq_flag_clear && !irq_edge) |=> !ext_irq_flag)
        else $error("irq flag not cleared");

    // Timer0 count
    a_t0_internal: assert property (@(posedge clk_sys) disable iff (rst)
        (!s_q.opt.timer_zero_clock_source && s_q.opt.prescaler_assignment &&
         !instruction_cycle_clock) |=> $stable(timer_zero_count))
        else $error("count moved without instruction clock");
    a_t0_external: assert property (@(posedge clk_sys) disable iff (rst)
        (s_q.opt.timer_zero_clock_source && s_q.opt.prescaler_assignment &&
         !t0_ext_edge) |=> $stable(timer_zero_count))
        else $error("count moved without pin edge");
    a_t0_edge_sel: assert property (@(posedge clk_sys) disable iff (rst)
        (s_q.opt.timer_zero_clock_source && s_q.opt.timer_zero_edge_select &&
         $fell(s_q.t0_s2)) |-> t0_src_pulse)
        else $error("pin edge missed");
    a_t0_bypass: assert property (@(posedge clk_sys) disable iff (rst)
        (s_q.opt.prescaler_assignment && t0_src_pulse) |=>
        timer_zero_count == $past(timer_zero_count) + 8'h01)
        else $error("undivided count failed");
    a_t0_divided: assert property (@(posedge clk_sys) disable iff (rst)
        (!s_q.opt.prescaler_assignment && !presc_out) |=> $stable(timer_zero_count))
        else $error("count moved without prescaler output");
    a_ovf_wrap: assert property (@(posedge clk_sys) disable iff (rst)
        timer_zero_overflow |-> timer_zero_count == 8'h00)
        else $error("overflow without wrap");
    a_ovf_pulse: assert property (@(posedge clk_sys) disable iff (rst)
        timer_zero_overflow |=> !timer_zero_overflow)
        else $error("overflow pulse too long");

    // Shared prescaler
    a_presc_route: assert property (@(posedge clk_sys) disable iff (rst)
        (!s_q.opt.prescaler_assignment && !t0_src_pulse) |=> !presc_out)
        else $error("watchdog tick reached timer divider");
    a_presc_hold: assert property (@(posedge clk_sys) disable iff (rst)
        (!presc_in && !presc_clr) |=> $stable(u_presc.s_q.count))
        else $error("divider moved without input");
    a_div2_min: assert property (@(posedge clk_sys) disable iff (rst)
        (!s_q.opt.prescaler_assignment && presc_out) |=> !presc_out)
        else $error("timer divider too fast");
    a_wd_unity: assert property (@(posedge clk_sys) disable iff (rst)
        (s_q.opt.prescaler_assignment && s_q.opt.prescale_rate_code == 3'h0 &&
         watchdog_clock_tick && !opt_wr) |=> watchdog_timeout_tick)
        else $error("watchdog 1:1 tick lost");
    a_wd_divided: assert property (@(posedge clk_sys) disable iff (rst)
        (s_q.opt.prescaler_assignment && s_q.opt.prescale_rate_code != 3'h0 &&
         watchdog_timeout_tick && !opt_wr) |=> !watchdog_timeout_tick)
        else $error("watchdog divider too fast");
    a_presc_clear: assert property (@(posedge clk_sys) disable iff (rst)
        opt_wr |=> u_presc.s_q.count == `TPO_PRESC_ZERO)
        else $error("prescaler not cleared");

    // Scenarios the bench should reach
    c_write: cover property (@(posedge clk_sys) opt_wr);
    c_overflow: cover property (@(posedge clk_sys) timer_zero_overflow);
    c_irq: cover property (@(posedge clk_sys) irq_edge && ext_irq_flag_clear);
    c_wd_tick: cover property (@(posedge clk_sys)
        s_q.opt.prescaler_assignment && watchdog_timeout_tick);
    c_ext_count: cover property (@(posedge clk_sys)
        s_q.opt.timer_zero_clock_source && t0_ext_edge);
endmodule : tpo_option_ctrl

// file: tpo_pkg.sv
// Types shared by the option control block
package tpo_pkg;
    typedef struct packed {
        logic       port_pullup_disable_n;
        logic       ext_irq_edge_select;
        logic       timer_zero_clock_source;
        logic       timer_zero_edge_select;
        logic       prescaler_assignment;
        logic [2:0] prescale_rate_code;
    } tpo_option_t;

    typedef struct packed {
        logic [7:0] count;
        logic       tick;
    } tpo_presc_state_t;

    typedef struct packed {
        tpo_option_t opt;
        logic        t0_s1;
        logic        t0_s2;
        logic        t0_prev;
        logic        irq_s1;
        logic        irq_s2;
        logic        irq_prev;
        logic        irq_flag;
        logic [7:0]  timer_zero_count;
        logic        t0_overflow;
    } tpo_state_t;
endpackage : tpo_pkg

// file: tpo_prescaler.sv
// Shared 8-bit ripple-style prescaler with selectable tap
`timescale 1ns/100ps
`include "tpo_consts.svh"
module tpo_prescaler #(
    parameter int W = `TPO_PRESC_W
) (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       clr,
    input  wire logic       in_pulse,
    input  wire logic [2:0] tap,
    input  wire logic       bypass,
    output logic            out_pulse
);
    tpo_pkg::tpo_presc_state_t s_q;
    tpo_pkg::tpo_presc_state_t s_d;
    logic [W-1:0] nxt;

    // Output pulses when the tapped bit carries, giving 1:2^(tap+1)
    function automatic logic carry_at(input logic [W-1:0] c, input logic [2:0] t);
        logic [W-1:0] m;
        // Widen before adding so tap 7 shifts by 8 instead of wrapping to 0
        m = (W'(1) << ({1'b0, t} + 4'h1)) - W'(1);
        carry_at = ((c & m) == m);
    endfunction : carry_at

    always_comb begin
        s_d      = s_q;
        s_d.tick = 1'b0;
        nxt      = s_q.count;
        if (clr) begin
            s_d.count = `TPO_PRESC_ZERO;
        end else if (in_pulse) begin
            if (bypass) begin
                s_d.tick = 1'b1;
            end else begin
                s_d.tick  = carry_at(s_q.count, tap);
                nxt       = s_q.count + W'(1);
                s_d.count = nxt;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign out_pulse = s_q.tick;
endmodule : tpo_prescaler
